// ### core/pla_map.vh
// address map, field positions and codes of the macrocell array
`ifndef PLA_MAP_VH
`define PLA_MAP_VH
// apb byte addresses
`define PLA_CFG_TOP 13'h0FFC
`define PLA_OPT_ADDR 13'h1000
`define PLA_STATE_ADDR 13'h1004
`define PLA_FB_ADDR 13'h1008
// per-macrocell configuration block: 32 words
`define PLA_MC_WORDS 32
`define PLA_PT_WORDS 5
`define PLA_CTRL_A 25
`define PLA_CTRL_B 26
`define PLA_CFG_WORDS 1024
`define PLA_RST_WORD 32'h0000_0000
// option word fields
`define PLA_O_PD 0
`define PLA_O_KEEP_DIS 1
// control word a fields
`define PLA_A_OR 4:0
`define PLA_A_CAS 5
`define PLA_A_XOR 7:6
`define PLA_A_DSRC 8
`define PLA_A_MODE 11:9
`define PLA_A_CKSEL 12
`define PLA_A_CEUSE 13
`define PLA_A_RST 15:14
`define PLA_A_PRE 16
`define PLA_A_REGOUT 17
`define PLA_A_FBREG 18
`define PLA_A_OE 21:19
`define PLA_A_KEEP_DIS 22
`define PLA_A_OE1PIN 24:23
`define PLA_A_OE2PIN 26:25
// control word b: term and pin select fields
`define PLA_B_XORPT 2:0
`define PLA_B_DPT 5:3
`define PLA_B_CKPT 8:6
`define PLA_B_CEPT 11:9
`define PLA_B_RSTPT 14:12
`define PLA_B_PREPT 17:15
`define PLA_B_OEPT 20:18
`define PLA_B_AUXPT 23:21
`define PLA_B_FOLDPT 26:24
`define PLA_B_CKPIN 28:27
`define PLA_B_CLRPIN 30:29
// codes
`define PLA_XOR_LOW 2'h0
`define PLA_XOR_HIGH 2'h1
`define PLA_XOR_PT 2'h2
`define PLA_FF_D 3'h0
`define PLA_FF_T 3'h1
`define PLA_FF_JK 3'h2
`define PLA_FF_SR 3'h3
`define PLA_FF_LATCH 3'h4
`define PLA_RST_OFF 2'h0
`define PLA_RST_PIN 2'h1
`define PLA_RST_PT 2'h2
`define PLA_RST_OR 2'h3
`define PLA_OE_OFF 3'h0
`define PLA_OE_ON 3'h1
`define PLA_OE_PIN1 3'h2
`define PLA_OE_PIN2 3'h3
`define PLA_OE_PT 3'h4
`endif

// ### core/pla_macrocell_array.v
// macrocell array: product terms, sum/xor/cascade, storage, outputs, apb config
`include "pla_map.vh"

// Overview of operation
// - dedicated pins selectable as clock, clear, enable
// - five product terms over global and regional
// - sum ors terms plus cascade, chains to forty
// - xor sum with term or constant
// - storage data from xor or term
// - storage modes d, t, jk, sr, latch
// - latch transparent while clock high
// - clock from pin or term, rising edge
// - term enable gates pin clock edges
// - reset from pin, term, both, none
// - preset from term or none
// - clear and enables low, power-down high
// - registered output feeds same value back
// - combinational feedback, register only with term data
// - buffer enable on, off, pins, term
// - global bus of pins and feedbacks
// - inverted foldback term onto regional bus
// - power-down freezes logic and ignores pins
// - power-down pin not a logic pin
// - keeper holds last driven pin level
module pla_macrocell_array
#(
   parameter MC_NUM = 32, // macrocells, one per i/o pin
   parameter DED_NUM = 4, // dedicated input pins
   parameter REGION = 16, // macrocells sharing a foldback bus
   parameter CHAIN = 8, // macrocells per cascade chain
   parameter PD_PIN = 31 // i/o pin doubling as power-down
)
(
   input wire clk,
   input wire nrst,
   input wire [12:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [DED_NUM-1:0] ded_in,
   input wire [DED_NUM-1:0] ded_z,
   input wire [MC_NUM-1:0] io_i,
   input wire [MC_NUM-1:0] io_z,
   output wire [MC_NUM-1:0] io_o,
   output wire [MC_NUM-1:0] io_oe_n
);

   // literal count: global bus true and complement plus region foldbacks
   localparam GB_W = DED_NUM + 2 * MC_NUM;
   localparam LIT_W = 2 * GB_W + REGION;

   // product term: and of every connected literal, empty mask gives one
   function pla_and;
      input [32*`PLA_PT_WORDS-1:0] mask;
      input [LIT_W-1:0] lits;
      begin
         pla_and = &(lits | ~mask[LIT_W-1:0]);
      end
   endfunction

   // term select mux: index five and above reads as low
   function pla_pick;
      input [4:0] terms;
      input [2:0] idx;
      begin
         pla_pick = (idx < 3'h5) ? terms[idx] : 1'b0;
      end
   endfunction

   // configuration storage, written only by software
   reg [31:0] cfg_q [0:`PLA_CFG_WORDS-1];
   reg [1:0] opt_q; // power-down option, input keeper disable
   reg [31:0] rdata_q; // read data caught in setup phase

   // macrocell state
   reg [MC_NUM-1:0] q_q; // storage elements
   reg [MC_NUM-1:0] fb_q; // buried feedback on the global bus
   reg [MC_NUM-1:0] fold_q; // foldback terms on regional buses
   reg [MC_NUM-1:0] ptclk_prev_q; // last level of term clocks
   reg [DED_NUM-1:0] ded_prev_q; // last level of dedicated pins
   reg [MC_NUM-1:0] io_o_q; // pin output data
   reg [MC_NUM-1:0] io_oe_n_q; // pin output enables, low drives
   reg [MC_NUM-1:0] io_keep_q; // keeper levels of i/o pins
   reg [DED_NUM-1:0] ded_keep_q; // keeper levels of dedicated pins

   // combinational next values from the macrocells
   wire [MC_NUM-1:0] q_d;
   wire [MC_NUM-1:0] fb_d;
   wire [MC_NUM-1:0] fold_d;
   wire [MC_NUM-1:0] ptclk_d;
   wire [MC_NUM-1:0] out_d;
   wire [MC_NUM-1:0] oe_d;
   wire [MC_NUM-1:0] sum_w; // sum terms, also cascade outputs
   wire [MC_NUM-1:0] io_lvl; // pin level as the array sees it
   wire [DED_NUM-1:0] ded_lvl;
   wire [MC_NUM-1:0] io_bus; // pins as placed on the global bus
   wire [GB_W-1:0] gbus;
   wire pd_freeze;
   integer i; // keeper loop index
   integer j; // config reset loop index, kept apart from the keeper loop

   // keeper: a floating pin reads its last driven level
   assign io_lvl = (~io_oe_n_q & io_o_q) | (io_oe_n_q & ~io_z & io_i) |
                   (io_oe_n_q & io_z & io_keep_q);
   assign ded_lvl = opt_q[`PLA_O_KEEP_DIS] ? ded_in :
                    ((~ded_z & ded_in) | (ded_z & ded_keep_q));

   // power-down pin is active high and only looked at live
   assign pd_freeze = opt_q[`PLA_O_PD] & io_lvl[PD_PIN];

   // with the option on, the power-down pin leaves the global bus
   generate
      genvar p;
      for (p = 0; p < MC_NUM; p = p + 1)
      begin : g_bus
         if (p == PD_PIN)
         begin : g_pd
            assign io_bus[p] = io_lvl[p] & ~opt_q[`PLA_O_PD];
         end
         else
         begin : g_io
            assign io_bus[p] = io_lvl[p];
         end
      end
   endgenerate

   // global bus: dedicated pins, i/o pins, buried feedbacks
   assign gbus = {fb_q, io_bus, ded_lvl};

   // one macrocell per index
   generate
      genvar g;
      genvar k;
      for (g = 0; g < MC_NUM; g = g + 1)
      begin : g_mc
         wire [31:0] ca;
         wire [31:0] cb;
         wire [LIT_W-1:0] lits;
         wire [4:0] pt;
         wire cas_in; // cascade input from the previous cell
         wire xor_w; // combinational result
         wire d_w; // storage data
         wire aux_w; // k or r term
         wire ck_lvl; // selected clock level
         wire rise_w;
         wire ce_w;
         wire clr_w; // clear pin active
         wire rst_w;
         wire pre_w;
         reg nxt_w;
         reg oe_w;
         reg rst_sel_w;

         // configuration words are fixed at programming time
         assign ca = cfg_q[g*`PLA_MC_WORDS + `PLA_CTRL_A];
         assign cb = cfg_q[g*`PLA_MC_WORDS + `PLA_CTRL_B];

         // global bus both polarities plus this region's foldbacks
         assign lits = {fold_q[(g/REGION)*REGION +: REGION], ~gbus, gbus};

         // five product terms from five masks of five words each
         for (k = 0; k < `PLA_PT_WORDS; k = k + 1)
         begin : g_pt
            assign pt[k] = pla_and({cfg_q[g*`PLA_MC_WORDS + k*`PLA_PT_WORDS + 4],
                                    cfg_q[g*`PLA_MC_WORDS + k*`PLA_PT_WORDS + 3],
                                    cfg_q[g*`PLA_MC_WORDS + k*`PLA_PT_WORDS + 2],
                                    cfg_q[g*`PLA_MC_WORDS + k*`PLA_PT_WORDS + 1],
                                    cfg_q[g*`PLA_MC_WORDS + k*`PLA_PT_WORDS]}, lits);
         end

         // the first cell of each chain has nothing to cascade from
         if (g % CHAIN == 0)
         begin : g_head
            assign cas_in = 1'b0;
         end
         else
         begin : g_link
            assign cas_in = sum_w[g-1];
         end

         // sum term with optional cascade, eight cells give forty
         assign sum_w[g] = |(pt & ca[`PLA_A_OR]) | (ca[`PLA_A_CAS] & cas_in);

         // xor against term or constant: polarity and t emulation
         assign xor_w = sum_w[g] ^ ((ca[`PLA_A_XOR] == `PLA_XOR_PT) ?
                        pla_pick(pt, cb[`PLA_B_XORPT]) :
                        (ca[`PLA_A_XOR] == `PLA_XOR_HIGH));

         // storage data from xor or a separate term
         assign d_w = ca[`PLA_A_DSRC] ? pla_pick(pt, cb[`PLA_B_DPT]) : xor_w;
         assign aux_w = pla_pick(pt, cb[`PLA_B_AUXPT]);

         // clock from a dedicated pin or a product term
         assign ptclk_d[g] = pla_pick(pt, cb[`PLA_B_CKPT]);
         assign ck_lvl = ca[`PLA_A_CKSEL] ? ptclk_d[g] : ded_lvl[cb[`PLA_B_CKPIN]];
         assign rise_w = ca[`PLA_A_CKSEL] ? (ptclk_d[g] & ~ptclk_prev_q[g]) :
                         (ded_lvl[cb[`PLA_B_CKPIN]] & ~ded_prev_q[cb[`PLA_B_CKPIN]]);

         // enable term only gates the pin clock
         assign ce_w = ca[`PLA_A_CKSEL] | ~ca[`PLA_A_CEUSE] |
                       pla_pick(pt, cb[`PLA_B_CEPT]);

         // clear pin is active low
         assign clr_w = ~ded_lvl[cb[`PLA_B_CLRPIN]];

         // reset source select
         always @*
         begin
            case (ca[`PLA_A_RST])
               `PLA_RST_PIN: rst_sel_w = clr_w;
               `PLA_RST_PT: rst_sel_w = pla_pick(pt, cb[`PLA_B_RSTPT]);
               `PLA_RST_OR: rst_sel_w = clr_w | pla_pick(pt, cb[`PLA_B_RSTPT]);
               default: rst_sel_w = 1'b0;
            endcase
         end
         assign rst_w = rst_sel_w;

         // preset is a term or never
         assign pre_w = ca[`PLA_A_PRE] & pla_pick(pt, cb[`PLA_B_PREPT]);

         // value taken at an enabled rising edge
         always @*
         begin
            case (ca[`PLA_A_MODE])
               `PLA_FF_T: nxt_w = q_q[g] ^ d_w;
               `PLA_FF_JK: nxt_w = (d_w & ~q_q[g]) | (~aux_w & q_q[g]);
               `PLA_FF_SR: nxt_w = d_w | (~aux_w & q_q[g]);
               default: nxt_w = d_w;
            endcase
         end

         // reset beats preset; latch follows while clock high
         assign q_d[g] = rst_w ? 1'b0 : pre_w ? 1'b1 :
                         (ca[`PLA_A_MODE] == `PLA_FF_LATCH) ?
                         (ck_lvl ? d_w : q_q[g]) :
                         ((rise_w & ce_w) ? nxt_w : q_q[g]);

         // registered output feeds the same value back
         assign out_d[g] = ca[`PLA_A_REGOUT] ? q_d[g] : xor_w;

         // combinational feedback may take the register only with term data
         assign fb_d[g] = (ca[`PLA_A_REGOUT] |
                          (ca[`PLA_A_FBREG] & ca[`PLA_A_DSRC])) ? q_d[g] : xor_w;

         // inverted copy of one term onto the regional bus
         assign fold_d[g] = ~pla_pick(pt, cb[`PLA_B_FOLDPT]);

         // buffer enable select; enable pins are active low
         always @*
         begin
            case (ca[`PLA_A_OE])
               `PLA_OE_ON: oe_w = 1'b1;
               `PLA_OE_PIN1: oe_w = ~ded_lvl[ca[`PLA_A_OE1PIN]];
               `PLA_OE_PIN2: oe_w = ~ded_lvl[ca[`PLA_A_OE2PIN]];
               `PLA_OE_PT: oe_w = pla_pick(pt, cb[`PLA_B_OEPT]);
               default: oe_w = 1'b0;
            endcase
         end

         // power-down pin never drives when the option is on
         if (g == PD_PIN)
         begin : g_pdoe
            assign oe_d[g] = oe_w & ~opt_q[`PLA_O_PD];
         end
         else
         begin : g_oe
            assign oe_d[g] = oe_w;
         end
      end
   endgenerate

   // macrocell state; a frozen device holds every flop in this block
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         q_q <= {MC_NUM{1'b0}};
         fb_q <= {MC_NUM{1'b0}};
         fold_q <= {MC_NUM{1'b1}}; // held high in reset, though an empty term inverts to low
         ptclk_prev_q <= {MC_NUM{1'b0}};
         io_o_q <= {MC_NUM{1'b0}};
         io_oe_n_q <= {MC_NUM{1'b1}}; // all buffers off in reset
      end
      else if (!pd_freeze)
      begin
         q_q <= q_d;
         fb_q <= fb_d;
         fold_q <= fold_d;
         ptclk_prev_q <= ptclk_d;
         io_o_q <= out_d;
         // a disabled buffer leaves the cell working inside
         io_oe_n_q <= ~oe_d;
      end
   end

   // pin history always follows, so edges seen while frozen are lost
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ded_prev_q <= {DED_NUM{1'b0}};
         io_keep_q <= {MC_NUM{1'b0}};
         ded_keep_q <= {DED_NUM{1'b0}};
      end
      else
      begin
         ded_prev_q <= ded_lvl;
         // keeper tracks the resolved level of each pin, or the raw input where its cell disables keeping
         for (i = 0; i < MC_NUM; i = i + 1)
         begin
            if (cfg_q[i*`PLA_MC_WORDS + `PLA_CTRL_A][`PLA_A_KEEP_DIS])
               io_keep_q[i] <= io_i[i];
            else
               io_keep_q[i] <= io_lvl[i];
         end
         ded_keep_q <= ded_lvl;
      end
   end

   // apb decode
   wire apb_wr;
   wire apb_setup;
   wire cfg_hit;
   wire opt_hit;
   wire map_hit;
   assign apb_wr = psel & penable & pwrite;
   assign apb_setup = psel & ~penable;
   assign cfg_hit = (paddr <= `PLA_CFG_TOP);
   assign opt_hit = (paddr == `PLA_OPT_ADDR);
   assign map_hit = cfg_hit | opt_hit | (paddr == `PLA_STATE_ADDR) |
                    (paddr == `PLA_FB_ADDR);

   // zero wait states; unmapped address answers with an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~map_hit;
   assign prdata = rdata_q;

   // configuration writes; software programs before running
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (j = 0; j < `PLA_CFG_WORDS; j = j + 1)
            cfg_q[j] <= `PLA_RST_WORD;
         opt_q <= 2'h0;
      end
      else if (apb_wr & cfg_hit)
         cfg_q[paddr[11:2]] <= pwdata;
      else if (apb_wr & opt_hit)
         opt_q <= pwdata[1:0];
   end

   // read data caught in the setup cycle, stable through access
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rdata_q <= 32'h0000_0000;
      else if (apb_setup)
      begin
         if (cfg_hit)
            rdata_q <= cfg_q[paddr[11:2]];
         else if (opt_hit)
            rdata_q <= {30'h0000_0000, opt_q};
         else if (paddr == `PLA_STATE_ADDR)
            rdata_q <= q_q;
         else if (paddr == `PLA_FB_ADDR)
            rdata_q <= fb_q;
         else
            rdata_q <= 32'h0000_0000;
      end
   end

   // pins
   assign io_o = io_o_q;
   assign io_oe_n = io_oe_n_q;

endmodule // pla_macrocell_array

// ### dv/pla_monitor.sv
// pin-level checker for the macrocell array, bound to its top module
module pla_monitor
#(
   parameter MC_NUM = 32, // macrocells
   parameter DED_NUM = 4, // dedicated input pins
   parameter PD_PIN = 31 // i/o pin doubling as power-down
)
(
   input wire clk,
   input wire nrst,
   input wire [12:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   input wire pready,
   input wire [DED_NUM-1:0] ded_in,
   input wire [MC_NUM-1:0] io_i,
   input wire [MC_NUM-1:0] io_z,
   input wire [MC_NUM-1:0] io_o,
   input wire [MC_NUM-1:0] io_oe_n
);
   reg [31:0] a0_q; // shadow of cell 0 control word a
   reg [31:0] a1_q; // shadow of cell 1 control word a
   reg [31:0] b1_q; // shadow of cell 1 control word b
   reg opt_pd_q; // shadow of the power-down option
   wire wr = psel & penable & pwrite & pready; // write completing now
   wire act = !(opt_pd_q & io_i[PD_PIN] & ~io_z[PD_PIN]); // not frozen
   wire ck1 = ded_in[b1_q[28:27]]; // clock pin of cell 1
   wire clr1 = ded_in[b1_q[30:29]]; // clear pin of cell 1, low active
   // plain d register, pin clock, no reset or preset
   wire reg1 = a1_q[17] & (a1_q[16:14] == 3'h0) & (a1_q[12:9] == 4'h0);
   wire clr_on = a1_q[17] & (a1_q[15:14] == 2'h1); // registered, pin clear
   // shadow config from the bus, so checks only see settled settings
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         a0_q <= 32'h0000_0000;
         a1_q <= 32'h0000_0000;
         b1_q <= 32'h0000_0000;
         opt_pd_q <= 1'b0;
      end
      else if (wr)
      begin
         if (paddr == 13'h0064)
            a0_q <= pwdata;
         if (paddr == 13'h00E4)
            a1_q <= pwdata;
         if (paddr == 13'h00E8)
            b1_q <= pwdata;
         if (paddr == 13'h1000)
            opt_pd_q <= pwdata[0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // three samples leave room for the output register stage
   sequence frozen;
      (!act)[*3];
   endsequence
   sequence no_rise;
      (reg1 && act && !ck1)[*4];
   endsequence
   sequence pin_steady;
      (a0_q[21:19] == 3'h2 && act && $stable(ded_in))[*3];
   endsequence
   pd_hold_a: assert property (frozen |-> $stable(io_o))
      else $error("outputs moved while powered down");
   pd_oe_a: assert property (frozen |-> $stable(io_oe_n))
      else $error("enables moved while powered down");
   pd_pin_a: assert property (opt_pd_q [*3] |-> io_oe_n[PD_PIN])
      else $error("power-down pin driven as output");
   oe_off_a: assert property ((a0_q[21:19] == 3'h0)[*3] |-> io_oe_n[0])
      else $error("disabled buffer is driving");
   oe_on_a: assert property ((a0_q[21:19] == 3'h1 && act)[*3] |-> !io_oe_n[0])
      else $error("enabled buffer not driving");
   oe_pin_a: assert property (pin_steady |-> io_oe_n[0] == ded_in[a0_q[24:23]])
      else $error("pin enable polarity wrong");
   q_hold_a: assert property (no_rise |-> $stable(io_o[1]))
      else $error("register changed without rising clock");
   clr_pin_a: assert property ((clr_on && act && !clr1)[*3] |-> !io_o[1])
      else $error("register not cleared by clear pin");
endmodule // pla_monitor

bind pla_macrocell_array pla_monitor #(.MC_NUM(MC_NUM), .DED_NUM(DED_NUM), .PD_PIN(PD_PIN)) u_mon
(
   .clk(clk),
   .nrst(nrst),
   .paddr(paddr),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .pwdata(pwdata),
   .pready(pready),
   .ded_in(ded_in),
   .io_i(io_i),
   .io_z(io_z),
   .io_o(io_o),
   .io_oe_n(io_oe_n)
);

// ### dv/pla_board.sv
// board-side model driving the dedicated and i/o pins
module pla_board
#(
   parameter PD_PIN = 31 // i/o pin doubling as power-down
)
(
   input wire clk,
   input wire [3:0] ded_want,
   input wire [3:0] ded_float,
   input wire [31:0] io_want,
   input wire [31:0] io_float,
   input wire pd_req,
   input wire [31:0] io_o,
   input wire [31:0] io_oe_n,
   output logic [3:0] ded_in,
   output logic [3:0] ded_z,
   output logic [31:0] io_i,
   output logic [31:0] io_z
);
   logic [3:0] ded_last_q = 4'h0; // last level the board drove
   logic [31:0] io_last_q = 32'h0000_0000;
   // remember driven levels; a released line shows their inverse
   always @(posedge clk)
   begin
      ded_last_q <= (ded_float & ded_last_q) | (~ded_float & ded_want);
      io_last_q <= (io_float & io_last_q) | (~io_float & io_want);
   end
   // resolve wires; a released line must not look like a kept one
   always_comb
   begin
      ded_in = (ded_float & ~ded_last_q) | (~ded_float & ded_want);
      ded_z = ded_float;
      io_i = (io_float & ~io_oe_n & io_o) | (io_float & io_oe_n & ~io_last_q)
         | (~io_float & io_want);
      io_z = io_float;
      if (pd_req)
      begin
         io_i[PD_PIN] = 1'b1;
         io_z[PD_PIN] = 1'b0;
      end
   end
endmodule // pla_board

// ### dv/tb.sv
// self-checking bench for the macrocell array
`define CHK(nm, ex, got) \
   begin \
      checks++; \
      if ((got) !== (ex)) \
      begin \
         n_mismatch++; \
         $display("Error %s expected %h seen %h", nm, ex, got); \
      end \
   end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [12:0] paddr = 13'h0000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] ded_want = 4'h8; // clear pin idles high
   logic [3:0] ded_float = 4'h0;
   logic [31:0] io_want = 32'h0000_0000; // board levels on the i/o pins
   logic [31:0] io_float = 32'h0000_0000; // i/o pins left undriven by the board
   logic pd_req = 1'b0;
   logic [31:0] rd_q; // read data of last transfer
   logic err_q; // error flag of last transfer
   int checks = 0;
   int n_mismatch = 0;
   wire [31:0] prdata, io_o, io_oe_n, io_i, io_z;
   wire pready, pslverr;
   wire [3:0] ded_in, ded_z;
   pla_macrocell_array uut (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ded_in(ded_in), .ded_z(ded_z),
      .io_i(io_i), .io_z(io_z), .io_o(io_o), .io_oe_n(io_oe_n));
   pla_board u_board (.clk(clk), .ded_want(ded_want), .ded_float(ded_float),
      .io_want(io_want), .io_float(io_float), .pd_req(pd_req),
      .io_o(io_o), .io_oe_n(io_oe_n), .ded_in(ded_in), .ded_z(ded_z),
      .io_i(io_i), .io_z(io_z));
   initial
   begin
      forever #10 clk = ~clk;
   end
   task complete_run;
      if (n_mismatch == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task wt(input int k);
      repeat (k) @(posedge clk);
   endtask
   // one apb transfer; request held until pready is seen
   task apb(input logic [12:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no local limit: only the watchdog ends a wait that never answers
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // rising edge on the clock pin (dedicated pin 0)
   task tick;
      ded_want[0] <= 1'b1;
      wt(2);
      ded_want[0] <= 1'b0;
      wt(3);
   endtask
   task t_regs;
      apb(13'h0004, 1'b1, 32'h1234_5678);
      apb(13'h0004, 1'b0, 32'h0000_0000);
      `CHK("cfg", 32'h1234_5678, rd_q);
      apb(13'h0004, 1'b1, 32'h0000_0000);
      apb(13'h1010, 1'b0, 32'h0000_0000);
      `CHK("unmapped", 1'b1, err_q);
   endtask
   task t_comb;
      apb(13'h0000, 1'b1, 32'h0000_0002);
      for (int p = 0; p < 2; p++)
      begin
         apb(13'h0064, 1'b1, p ? 32'h0008_0041 : 32'h0008_0001);
         for (int v = 0; v < 2; v++)
         begin
            ded_want[1] <= v[0];
            wt(3);
            `CHK("comb", v[0] ^ p[0], io_o[0]);
            `CHK("oe_on", 1'b0, io_oe_n[0]);
         end
      end
   endtask
   task t_oe;
      for (int p = 0; p < 4; p++)
      begin
         apb(13'h0064, 1'b1, p[1] ? 32'h0618_0001 : 32'h0190_0001);
         ded_want[3] <= p[0];
         wt(3);
         `CHK("oe_pin", p[0], io_oe_n[0]);
      end
      apb(13'h0064, 1'b1, 32'h0000_0001);
      wt(3);
      `CHK("oe_off", 1'b1, io_oe_n[0]);
   endtask
   task t_dff;
      apb(13'h00E8, 1'b1, 32'h6000_0200);
      apb(13'h0080, 1'b1, 32'h0000_0002);
      apb(13'h0094, 1'b1, 32'h0000_0004);
      apb(13'h00E4, 1'b1, 32'h000A_2001);
      ded_want[2:1] <= 2'h3;
      wt(3);
      tick;
      `CHK("d_load", 1'b1, io_o[1]);
      ded_want[1] <= 1'b0;
      wt(4);
      `CHK("d_hold", 1'b1, io_o[1]);
      ded_want[2] <= 1'b0;
      tick;
      `CHK("ce_off", 1'b1, io_o[1]);
      ded_want[2] <= 1'b1;
      tick;
      `CHK("d_zero", 1'b0, io_o[1]);
      ded_want[1] <= 1'b1;
      apb(13'h00E4, 1'b1, 32'h000A_6201);
      tick;
      `CHK("t_one", 1'b1, io_o[1]);
      tick;
      `CHK("t_two", 1'b0, io_o[1]);
      tick;
      ded_want[3] <= 1'b0;
      wt(4);
      `CHK("clear", 1'b0, io_o[1]);
      ded_want[3] <= 1'b1;
      // latch gated by pin 0 level, data from pin 1
      apb(13'h00E4, 1'b1, 32'h000A_0801);
      ded_want[1:0] <= 2'h3;
      wt(4);
      `CHK("latch_open", 1'b1, io_o[1]);
      ded_want[1] <= 1'b0;
      wt(4);
      `CHK("latch_follow", 1'b0, io_o[1]);
      ded_want[1] <= 1'b1;
      wt(3);
      ded_want[0] <= 1'b0;
      wt(2);
      ded_want[1] <= 1'b0;
      wt(4);
      `CHK("latch_hold", 1'b1, io_o[1]);
   endtask
   task t_pd;
      apb(13'h0FE4, 1'b1, 32'h0008_0000); // cell 31 buffer always on
      apb(13'h0064, 1'b1, 32'h0008_0001);
      `CHK("pd_pin_drv", 1'b0, io_oe_n[31]);
      apb(13'h1000, 1'b1, 32'h0000_0001);
      ded_want[1] <= 1'b1;
      wt(3);
      pd_req <= 1'b1;
      wt(3);
      ded_want[1] <= 1'b0;
      wt(4);
      `CHK("pd_hold", 1'b1, io_o[0]);
      `CHK("pd_pin", 1'b1, io_oe_n[31]);
      pd_req <= 1'b0;
      wt(4);
      `CHK("pd_wake", 1'b0, io_o[0]);
   endtask
   task t_keep;
      ded_want[1] <= 1'b1;
      wt(3);
      ded_float[1] <= 1'b1;
      wt(4);
      `CHK("keep", 1'b1, io_o[0]);
      apb(13'h1000, 1'b1, 32'h0000_0002);
      wt(4);
      `CHK("no_keep", 1'b0, io_o[0]);
      ded_float[1] <= 1'b0;
   endtask
   // i/o pin, feedback, foldback and cascade paths through the array
   task t_bus;
      apb(13'h0100, 1'b1, 32'h0000_2000); // cell 2 term 0: i/o pin 9
      apb(13'h0164, 1'b1, 32'h0008_0001);
      apb(13'h0184, 1'b1, 32'h0000_0040); // cell 3 term 0: feedback of cell 2
      apb(13'h01E4, 1'b1, 32'h0008_0001);
      apb(13'h0210, 1'b1, 32'h0000_0400); // cell 4 term 0: foldback of cell 2
      apb(13'h0264, 1'b1, 32'h0008_0001);
      apb(13'h02E4, 1'b1, 32'h0008_0020); // cell 5: cascade from cell 4 only
      for (int v = 0; v < 2; v++)
      begin
         io_want[9] <= v[0];
         wt(4);
         `CHK("io_bus", v[0], io_o[2]);
         `CHK("fb_bus", v[0], io_o[3]);
         `CHK("fold_bus", !v[0], io_o[4]);
         `CHK("cascade", !v[0], io_o[5]);
      end
      io_float[9] <= 1'b1;
      wt(4);
      `CHK("io_keep", 1'b1, io_o[2]);
      io_float[9] <= 1'b0;
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_regs;
      t_comb;
      t_oe;
      t_dff;
      t_pd;
      t_keep;
      t_bus;
      complete_run;
   end
   // hang guard, well beyond the few hundred cycles the tests need
   initial
   begin
      #60000;
      n_mismatch++;
      complete_run;
   end
endmodule // tb
